// >>> logic/imr_regs.vh
`ifndef IMR_REGS_VH
`define IMR_REGS_VH
// operation codes on op_code
`define IMR_OP_W 3
`define IMR_OP_NONE 3'h0
`define IMR_OP_PRODUCT_TO_GPR 3'h1
`define IMR_OP_SIGNED_PRODUCT 3'h2
`define IMR_OP_UNSIGNED_PRODUCT 3'h3
`define IMR_OP_WRITE_UPPER 3'h4
`define IMR_OP_WRITE_BOTTOM 3'h5
`define IMR_OP_READ_UPPER 3'h6
`define IMR_OP_READ_BOTTOM 3'h7
// result register reset values
`define IMR_UPPER_RST 32'h0000_0000
`define IMR_BOTTOM_RST 32'h0000_0000
// product bit fields
`define IMR_LOW_MSB 31
`define IMR_HIGH_LSB 32
// default multiplier latency in cycles
`define IMR_MUL_LAT 4
`endif

// >>> logic/imr_mul_pipe.v
`timescale 1ns/1ps
`default_nettype none
`include "imr_regs.vh"
// pipelined 33x33 signed multiplier, fixed latency
module imr_mul_pipe #(
  parameter LAT = `IMR_MUL_LAT
) (
  input wire clk,
  input wire rst_n,
  input wire in_valid,
  input wire sign_ext,
  input wire [31:0] op_a,
  input wire [31:0] op_b,
  output wire out_valid,
  output wire [63:0] product
);
  reg [LAT-1:0] vld_q;
  wire signed [32:0] a_ext;
  wire signed [32:0] b_ext;
  wire signed [65:0] full;
  // a 33-bit operand serves signed and unsigned forms alike
  assign a_ext = {sign_ext & op_a[31], op_a};
  assign b_ext = {sign_ext & op_b[31], op_b};
  assign full = a_ext * b_ext;
  // stage 0 latches the product, later stages just delay it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vld_q <= {LAT{1'b0}};
    end else begin
      vld_q <= {vld_q[LAT-2:0], in_valid};
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < LAT; gi = gi + 1) begin : g_stage
      reg [63:0] prod_q;
      if (gi == 0) begin : g_head
        always @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            prod_q <= 64'h0000_0000_0000_0000;
          end else begin
            prod_q <= full[63:0];
          end
        end
      end else begin : g_tail
        // own register per stage, so no array has two writers
        always @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            prod_q <= 64'h0000_0000_0000_0000;
          end else begin
            prod_q <= g_stage[gi-1].prod_q;
          end
        end
      end
    end
  endgenerate
  assign out_valid = vld_q[LAT-1];
  assign product = g_stage[LAT-1].prod_q;
endmodule // imr_mul_pipe
`default_nettype wire

// >>> logic/imr_unit.v
`timescale 1ns/1ps
`default_nettype none
`include "imr_regs.vh"
// Notes on behaviour
// - write_upper_op after a pending result may leave bottom undefined
// - write_upper_op copies source_a register fully into upper register
// - write_bottom_op copies source_a register fully into bottom register
// - write_bottom_op after a pending result may leave upper undefined
// - writes to the pair may immediately follow a read, no spacing
// - product_to_gpr_op signed 32x32, low 32 bits to dest register
// - product_to_gpr_op leaves upper and bottom registers undefined
// - no multiply ever raises an arithmetic exception
// - signed_product_op low word to bottom, high word to upper
// - unsigned_product_op zero-extends operands, splits as signed form
// - reads of a pending destination stall until the result is ready
// - overlapped multiply gives same visible result as sequential
module imr_unit #(
  parameter LAT = `IMR_MUL_LAT
) (
  input wire clk,
  input wire rst_n,
  input wire op_valid,
  input wire [`IMR_OP_W-1:0] op_code,
  input wire [31:0] source_a_data,
  input wire [31:0] source_b_data,
  input wire [4:0] dest_field,
  input wire [4:0] gpr_read_a,
  input wire [4:0] gpr_read_b,
  input wire gpr_read_en,
  output reg issue_stall,
  output reg [31:0] upper_result_reg,
  output reg [31:0] bottom_result_reg,
  output reg rd_valid,
  output reg [31:0] rd_data,
  output reg gpr_we,
  output reg [4:0] gpr_waddr,
  output reg [31:0] gpr_wdata,
  output reg arith_exc
);
  // pending-result tracker, one-hot: idle, pair due, register due
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_PAIR_WAIT = 3'h2;
  localparam [2:0] ST_DEST_WAIT = 3'h4;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [4:0] pend_dest_q;
  reg [4:0] pend_dest_d;
  reg [31:0] upper_d;
  reg [31:0] bottom_d;
  reg rd_valid_d;
  reg [31:0] rd_data_d;
  reg gpr_we_d;
  reg [4:0] gpr_waddr_d;
  reg [31:0] gpr_wdata_d;
  wire mul_out_valid;
  wire [63:0] mul_product;
  wire is_mul_gpr;
  wire is_mul_pair;
  wire is_mul;
  wire is_wr_upper;
  wire is_wr_bottom;
  wire is_rd_upper;
  wire is_rd_bottom;
  wire is_rd;
  wire is_move;
  wire busy;
  wire pend_dest;
  wire gpr_hazard;
  wire stall;
  wire take;
  wire land_pair;
  wire land_dest;

  // op decode
  assign is_mul_gpr = op_code == `IMR_OP_PRODUCT_TO_GPR;
  assign is_mul_pair = op_code == `IMR_OP_SIGNED_PRODUCT ||
                       op_code == `IMR_OP_UNSIGNED_PRODUCT;
  assign is_mul = is_mul_gpr | is_mul_pair;
  assign is_wr_upper = op_code == `IMR_OP_WRITE_UPPER;
  assign is_wr_bottom = op_code == `IMR_OP_WRITE_BOTTOM;
  assign is_rd_upper = op_code == `IMR_OP_READ_UPPER;
  assign is_rd_bottom = op_code == `IMR_OP_READ_BOTTOM;
  assign is_rd = is_rd_upper | is_rd_bottom;
  assign is_move = is_wr_upper | is_wr_bottom;

  // tracker views used by the interlock
  assign busy = state_q != ST_IDLE;
  assign pend_dest = state_q == ST_DEST_WAIT;

  // dest register of a pending product read by a later op
  assign gpr_hazard = pend_dest && gpr_read_en &&
                      (gpr_read_a == pend_dest_q ||
                       gpr_read_b == pend_dest_q);

  // one multiplier in flight; pair reads and writes wait for it, so
  // the visible order always matches sequential execution
  assign stall = op_valid && (gpr_hazard ||
                 (busy && (is_mul || is_rd || is_move)));
  assign take = op_valid && !stall;

  // a landing product goes either to the pair or to the register file
  assign land_pair = mul_out_valid && state_q == ST_PAIR_WAIT;
  assign land_dest = mul_out_valid && pend_dest;

  imr_mul_pipe #(.LAT(LAT)) u_mul (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(take && is_mul),
    .sign_ext(op_code != `IMR_OP_UNSIGNED_PRODUCT),
    .op_a(source_a_data),
    .op_b(source_b_data),
    .out_valid(mul_out_valid),
    .product(mul_product)
  );

  // tracker next state; a product only starts from idle, because
  // every op but none stalls while one is in flight
  always @* begin
    state_d = state_q;
    pend_dest_d = pend_dest_q;
    case (state_q)
      ST_IDLE: begin
        if (take && is_mul) begin
          state_d = is_mul_gpr ? ST_DEST_WAIT : ST_PAIR_WAIT;
          pend_dest_d = dest_field;
        end
      end
      ST_PAIR_WAIT: begin
        if (mul_out_valid) begin
          state_d = ST_IDLE;
        end
      end
      ST_DEST_WAIT: begin
        if (mul_out_valid) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        // a broken one-hot code falls back to idle
        state_d = ST_IDLE;
      end
    endcase
  end

  // result pair next value: moves and a landing product never meet,
  // since moves stall while a product is pending
  always @* begin
    upper_d = upper_result_reg;
    bottom_d = bottom_result_reg;
    if (land_pair) begin
      bottom_d = mul_product[`IMR_LOW_MSB:0];
      upper_d = mul_product[63:`IMR_HIGH_LSB];
    end else if (take && is_wr_upper) begin
      // bottom kept; undefined is allowed, keeping it is simplest
      upper_d = source_a_data;
    end else if (take && is_wr_bottom) begin
      bottom_d = source_a_data;
    end
  end

  // reads answer next cycle, so a move may follow at once
  always @* begin
    rd_valid_d = take && is_rd;
    rd_data_d = rd_data;
    if (take && is_rd_upper) begin
      rd_data_d = upper_result_reg;
    end else if (take && is_rd_bottom) begin
      rd_data_d = bottom_result_reg;
    end
  end

  // register-file writeback of the low product word
  always @* begin
    gpr_we_d = land_dest;
    gpr_waddr_d = gpr_waddr;
    gpr_wdata_d = gpr_wdata;
    if (land_dest) begin
      gpr_waddr_d = pend_dest_q;
      gpr_wdata_d = mul_product[`IMR_LOW_MSB:0];
    end
  end

  // tracker registers; reset drops a product in flight
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      pend_dest_q <= 5'h00;
    end else begin
      state_q <= state_d;
      pend_dest_q <= pend_dest_d;
    end
  end

  // result pair registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      upper_result_reg <= `IMR_UPPER_RST;
      bottom_result_reg <= `IMR_BOTTOM_RST;
    end else begin
      upper_result_reg <= upper_d;
      bottom_result_reg <= bottom_d;
    end
  end

  // output registers: every port leaves straight from a flip-flop
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data <= 32'h0000_0000;
      gpr_we <= 1'b0;
      gpr_waddr <= 5'h00;
      gpr_wdata <= 32'h0000_0000;
      issue_stall <= 1'b0;
      arith_exc <= 1'b0;
    end else begin
      rd_valid <= rd_valid_d;
      rd_data <= rd_data_d;
      gpr_we <= gpr_we_d;
      gpr_waddr <= gpr_waddr_d;
      gpr_wdata <= gpr_wdata_d;
      // one cycle late, for information only
      issue_stall <= stall;
      arith_exc <= 1'b0; // overflow never flagged
    end
  end
endmodule // imr_unit
`default_nettype wire

// >>> tb/imr_unit_chk.sv
`timescale 1ns/1ps
`default_nettype none
module imr_unit_chk #(parameter LAT = 4) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic op_valid,
  input wire logic [2:0] op_code,
  input wire logic [31:0] source_a_data,
  input wire logic [31:0] source_b_data,
  input wire logic issue_stall,
  input wire logic [31:0] upper_result_reg,
  input wire logic [31:0] bottom_result_reg,
  input wire logic rd_valid,
  input wire logic [31:0] rd_data,
  input wire logic gpr_we,
  input wire logic [31:0] gpr_wdata,
  input wire logic arith_exc
);
  localparam int D = LAT + 1;
  logic [7:0] cnt_q;
  logic [63:0] prod_q;
  wire logic take = op_valid && cnt_q == 8'h00;
  wire logic mul = op_code != 3'h0 && op_code < 3'h4;
  wire logic sx = op_code != 3'h3;
  // busy window of a multiply; every op but none inside it must wait
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) cnt_q <= 8'h00;
    else if (take && mul) cnt_q <= 8'(LAT);
    else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
  // product kept at issue, since operands may change after
  always_ff @(posedge clk)
    if (take && mul)
      prod_q <= $signed({sx & source_a_data[31], source_a_data}) *
        $signed({sx & source_b_data[31], source_b_data});
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  up_copy_a: assert property (take && op_code == 3'h4 |=>
    upper_result_reg == $past(source_a_data)) else $error("upper copy");
  bot_copy_a: assert property (take && op_code == 3'h5 |=>
    bottom_result_reg == $past(source_a_data)) else $error("bottom copy");
  pair_prod_a: assert property (
    take && mul && op_code != 3'h1 |-> ##D
    {upper_result_reg, bottom_result_reg} == prod_q) else $error("pair");
  gpr_prod_a: assert property (take && op_code == 3'h1 |-> ##D
    gpr_we && gpr_wdata == prod_q[31:0]) else $error("gpr product");
  read_ans_a: assert property (
    take && op_code[2:1] == 2'h3 |=> rd_valid && rd_data == ($past(op_code[0])
    ? $past(bottom_result_reg) : $past(upper_result_reg))) else $error("read");
  stall_seen_a: assert property (
    cnt_q != 8'h00 && op_valid && op_code != 3'h0 |=> issue_stall)
    else $error("no stall");
  read_cause_a: assert property (rd_valid |-> $past(take) &&
    $past(op_code[2:1]) == 2'h3) else $error("stray read");
  exc_zero_a: assert property (!arith_exc) else $error("exc");
endmodule // imr_unit_chk
bind imr_unit imr_unit_chk #(.LAT(LAT)) chk (.clk, .rst_n, .op_valid,
  .op_code, .source_a_data, .source_b_data, .issue_stall, .upper_result_reg,
  .bottom_result_reg, .rd_valid, .rd_data, .gpr_we, .gpr_wdata, .arith_exc);
`default_nettype wire

// >>> tb/imr_gpr_model.sv
`timescale 1ns/1ps
`default_nettype none
module imr_gpr_model (
  input wire logic clk,
  input wire logic gpr_we,
  input wire logic [4:0] gpr_waddr,
  input wire logic [31:0] gpr_wdata
);
  logic [31:0] mem [32];
  // register file takes the writeback pulse like the core would
  always @(posedge clk)
    if (gpr_we) mem[gpr_waddr] <= gpr_wdata;
endmodule // imr_gpr_model
`default_nettype wire

// >>> tb/integer_multiply_result_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CK(x, y) begin checks_done++; if ((x) !== (y)) begin \
  mismatches++; $display("unexpected %0t bad value", $time); end end
module integer_multiply_result_regs_bench;
  logic clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0, rd_en = 1'b0;
  logic [2:0] op_code = 3'h0;
  logic [31:0] sa = 32'h0, sb = 32'h0, rd_data, up, bot, wd;
  logic stall, rdv, we, exc;
  logic [4:0] wa;
  logic [4:0] ra = 5'h00, rb = 5'h00;
  logic [63:0] p;
  int mismatches = 0, checks_done = 0;
  imr_unit uut (.clk, .rst_n, .op_valid, .op_code, .source_a_data(sa),
    .source_b_data(sb), .dest_field(5'h09), .gpr_read_a(ra),
    .gpr_read_b(rb), .gpr_read_en(rd_en), .issue_stall(stall),
    .upper_result_reg(up), .bottom_result_reg(bot), .rd_valid(rdv),
    .rd_data, .gpr_we(we), .gpr_waddr(wa), .gpr_wdata(wd), .arith_exc(exc));
  imr_gpr_model gm (.clk, .gpr_we(we), .gpr_waddr(wa), .gpr_wdata(wd));
  // free running clock
  always #2 clk = ~clk;
  // one op held across one sampling edge
  task op(input logic [2:0] c, input logic [31:0] a, b);
    op_valid = 1'b1;
    op_code = c;
    sa = a;
    sb = b;
    @(negedge clk);
  endtask
  // read held until answered, so a stall is ridden out
  task rd(input logic [2:0] c, input logic [31:0] e);
    op(c, 32'h0, 32'h0);
    for (int i = 0; i < 9 && rdv !== 1'b1; i++) @(negedge clk);
    `CK(rd_data, e)
  endtask
  // both pair multiply kinds, signed and unsigned, reads issued at once
  task t_prod;
    for (int s = 0; s < 2; s++) begin
      p = {{32{s[0]}}, 32'hFFFF_FFFE} * 64'h0000_0000_0000_0003;
      op(s ? 3'h2 : 3'h3, 32'hFFFF_FFFE, 32'h0000_0003);
      rd(3'h6, p[63:32]);
      rd(3'h7, p[31:0]);
    end
  endtask
  // writes straight after reads, each half read back
  task t_move;
    op(3'h4, 32'hA5A5_0001, 32'h0);
    rd(3'h6, 32'hA5A5_0001);
    op(3'h5, 32'h0123_8765, 32'h0);
    rd(3'h7, 32'h0123_8765);
  endtask
  // reset with a product in flight: pair cleared, nothing left pending
  task t_rst;
    op(3'h2, 32'h0000_0007, 32'h0000_0005);
    op_valid = 1'b0;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    `CK(bot, 32'h0000_0000)
    op(3'h6, 32'h0, 32'h0);
    `CK(rdv, 1'b1)
    `CK(rd_data, 32'h0000_0000)
  endtask
  // product to register file; readers of its dest held off, others not
  task t_gpr;
    op(3'h1, 32'h8000_0000, 32'h0000_0003);
    rd_en = 1'b1;
    ra = 5'h09;
    op(3'h0, 32'h0, 32'h0);
    `CK(stall, 1'b1)
    ra = 5'h00;
    rb = 5'h09;
    op(3'h0, 32'h0, 32'h0);
    `CK(stall, 1'b1)
    rb = 5'h03;
    op(3'h0, 32'h0, 32'h0);
    `CK(stall, 1'b0)
    rd_en = 1'b0;
    rb = 5'h00;
    repeat (4) @(negedge clk);
    `CK(gm.mem[9], 32'h8000_0000)
    `CK(exc, 1'b0)
  endtask
  task close_out;
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // reset, then the scenarios
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    t_prod;
    t_move;
    t_rst;
    t_gpr;
    close_out;
  end
  // hang guard, many times the expected run
  initial begin
    #4000;
    mismatches++;
    close_out;
  end
endmodule // integer_multiply_result_regs_bench
`default_nettype wire
